// [fwg_defs.svh]
`ifndef FWG_DEFS_SVH
`define FWG_DEFS_SVH
// array geometry: 64 KB blocks
`define FWG_BLK_W 9
`define FWG_BLOCKS 10'h200
`define FWG_LEVEL_ALL 4'hA
// latch commands and the ungated volatile bank write
`define FWG_OP_LATCH_SET 8'h06
`define FWG_OP_LATCH_CLR 8'h04
`define FWG_OP_VBANK_WR 8'hC5
// array program opcodes
`define FWG_OP_PP 8'h02
`define FWG_OP_PP_LONG 8'h12
`define FWG_OP_QPP_A 8'h32
`define FWG_OP_QPP_B 8'h38
`define FWG_OP_QPP_LONG_A 8'h34
`define FWG_OP_QPP_LONG_B 8'h3E
// array erase opcodes
`define FWG_OP_SE_A 8'hD7
`define FWG_OP_SE_B 8'h20
`define FWG_OP_SE_LONG 8'h21
`define FWG_OP_HBE 8'h52
`define FWG_OP_HBE_LONG 8'h5C
`define FWG_OP_BE 8'hD8
`define FWG_OP_BE_LONG 8'hDC
`define FWG_OP_CE_A 8'hC7
`define FWG_OP_CE_B 8'h60
// register and protection opcodes
`define FWG_OP_SR_WR 8'h01
`define FWG_OP_FR_WR 8'h42
`define FWG_OP_RP_NV 8'h65
`define FWG_OP_ERP_NV 8'h85
`define FWG_OP_IR_ERASE 8'h64
`define FWG_OP_IR_PROG 8'h62
`define FWG_OP_BOOT_WR 8'h15
`define FWG_OP_NVBANK_WR 8'h18
`define FWG_OP_SP_PROG 8'hFD
`define FWG_OP_SP_PROG_LONG 8'hE3
`define FWG_OP_SP_ERASE 8'hE4
`define FWG_OP_SCHEME_PROG 8'h2F
`define FWG_OP_LOCK_WR 8'hA6
`define FWG_OP_FREEZE 8'h91
`define FWG_OP_PWD_PROG 8'hE8
// status and function byte field positions
`define FWG_SR_BUSY 0
`define FWG_SR_LATCH 1
`define FWG_SR_LVL_LO 2
`define FWG_SR_QUAD 6
`define FWG_SR_LOCK 7
`define FWG_FR_SIDE 1
// register offsets
`define FWG_REG_STATUS 2'h0
`define FWG_REG_FUNC 2'h1
`define FWG_REG_REJECTS 2'h2
`endif

// [fwg_guard.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fwg_defs.svh"

module fwg_guard
    import fwg_pkg::*;
#(
    parameter int REJ_LIMIT = 255
) (
    // clock and synchronous reset
    input wire logic MCLK,
    input wire logic RESET_N,
    // framed instruction from the host side
    input wire fwg_cmd_t CMD,
    input wire logic CMD_VALID,
    input wire logic ADDR4_MODE,
    // array engine finished the granted work
    input wire logic OP_DONE,
    // write-protect pin, low protects
    input wire logic WP_N,
    // register port
    input wire logic [1:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    // read data, one cycle after the strobe
    output logic [7:0] REG_RDATA,
    // hand-off to the array engine
    output logic GRANT,
    output logic [7:0] GRANT_OPCODE,
    output logic GRANT_LONG_ADDR,
    // refusal pulse, only the refusal count moves
    output logic REJECT,
    // status levels
    output logic BUSY,
    output logic WRITE_LATCH,
    // pin function selects
    output logic QUAD_IO_EN,
    output logic WP_FUNC_EN,
    output logic PAUSE_FUNC_EN
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    // the counter is eight bits wide and must count at least once
    if (REJ_LIMIT < 1 || REJ_LIMIT > 255) begin : g_bad_limit
        $error("REJ_LIMIT must lie in 1..255");
    end

    // saturation value at counter width
    localparam logic [7:0] REJ_MAX = 8'(REJ_LIMIT);

    ////////////////////////////////////////////////////////////////////////////
    // opcode classification

    // opcodes that need the latch flag first
    function automatic logic is_gated(input logic [7:0] op);
        // result, clear unless listed
        logic g;
        g = 1'b0;
        unique case (op)
            // page programs
            `FWG_OP_PP, `FWG_OP_QPP_A, `FWG_OP_QPP_B,
            `FWG_OP_QPP_LONG_A, `FWG_OP_QPP_LONG_B: g = 1'b1;
            // long address page program
            `FWG_OP_PP_LONG: g = 1'b1;
            // sector, full block and whole array erase
            `FWG_OP_SE_A, `FWG_OP_SE_B, `FWG_OP_BE,
            `FWG_OP_BE_LONG, `FWG_OP_CE_A, `FWG_OP_CE_B: g = 1'b1;
            // half block and long sector erase
            `FWG_OP_HBE, `FWG_OP_HBE_LONG, `FWG_OP_SE_LONG: g = 1'b1;
            // status, function, read parameter writes
            `FWG_OP_SR_WR, `FWG_OP_FR_WR, `FWG_OP_RP_NV: g = 1'b1;
            // extended parameter, boot, bank writes
            `FWG_OP_ERP_NV, `FWG_OP_BOOT_WR, `FWG_OP_NVBANK_WR: g = 1'b1;
            // sector protection and password family
            `FWG_OP_SP_PROG, `FWG_OP_SP_PROG_LONG, `FWG_OP_SP_ERASE,
            `FWG_OP_SCHEME_PROG, `FWG_OP_FREEZE, `FWG_OP_PWD_PROG: g = 1'b1;
            // information row and lock bit write
            `FWG_OP_IR_ERASE, `FWG_OP_IR_PROG, `FWG_OP_LOCK_WR: g = 1'b1;
            // everything else passes the gate untouched
            default: g = 1'b0;
        endcase
        return g;
    endfunction

    // opcodes that program or erase a block of the main array
    function automatic logic is_array_op(input logic [7:0] op);
        // result, clear unless listed
        logic a;
        a = 1'b0;
        unique case (op)
            // programs and erases with a block address
            `FWG_OP_PP, `FWG_OP_PP_LONG, `FWG_OP_QPP_A, `FWG_OP_QPP_B,
            `FWG_OP_QPP_LONG_A, `FWG_OP_QPP_LONG_B,
            `FWG_OP_SE_A, `FWG_OP_SE_B, `FWG_OP_SE_LONG,
            `FWG_OP_HBE, `FWG_OP_HBE_LONG, `FWG_OP_BE, `FWG_OP_BE_LONG: a = 1'b1;
            // no block address carried
            default: a = 1'b0;
        endcase
        return a;
    endfunction

    // opcodes that always carry a four-byte address
    function automatic logic is_long_op(input logic [7:0] op);
        // result, clear unless listed
        logic l;
        l = 1'b0;
        unique case (op)
            // long page program
            `FWG_OP_PP_LONG: l = 1'b1;
            // the other long-address forms
            `FWG_OP_QPP_LONG_A, `FWG_OP_QPP_LONG_B, `FWG_OP_SE_LONG,
            `FWG_OP_HBE_LONG, `FWG_OP_BE_LONG, `FWG_OP_SP_PROG_LONG: l = 1'b1;
            // width follows the current address mode
            default: l = 1'b0;
        endcase
        return l;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // block protection decode

    // true when a block lies inside the region picked by level and side
    function automatic logic blk_protected(
        input logic [3:0] lvl,
        input logic side,
        input logic [`FWG_BLK_W-1:0] blk
    );
        // length of the protected region in blocks
        logic [9:0] span;
        // result
        logic hit;
        span = 10'h000;
        hit = 1'b0;
        if (lvl >= `FWG_LEVEL_ALL) begin
            // codes ten and up cover the whole array, side ignored
            hit = 1'b1;
        end else if (lvl != 4'h0) begin
            // region is 2^(n-1) blocks long
            span = 10'h001 << (lvl - 4'h1);
            if (side) begin
                // bottom: from block zero upward
                hit = ({1'b0, blk} < span);
            end else begin
                // top: ending at the last block
                hit = ({1'b0, blk} >= (`FWG_BLOCKS - span));
            end
        end
        // code zero leaves hit clear: nothing protected
        return hit;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    // registered state
    fwg_state_t s_q;
    // next state
    fwg_state_t s_d;

    // status byte as software and the host see it
    logic [7:0] status_byte;
    // function byte: only the side select is kept here
    logic [7:0] func_byte;
    // write-protect pin level that counts; a data line when quad is on
    logic wp_high;
    // decoded checks for the framed instruction
    // opcode needs the latch flag
    logic gated;
    // opcode targets a block of the array
    logic array_op;
    // opcode erases the whole array
    logic whole_erase;
    // target block lies in the protected region
    logic hit;
    // status bits frozen by lock bit and pin
    logic sr_locked;

    ////////////////////////////////////////////////////////////////////////////
    // combinational helpers

    // read views and instruction checks
    always_comb begin
        status_byte = 8'h00;
        status_byte[`FWG_SR_BUSY] = s_q.busy;
        status_byte[`FWG_SR_LATCH] = s_q.latch;
        status_byte[`FWG_SR_LVL_LO +: 4] = s_q.level;
        status_byte[`FWG_SR_QUAD] = s_q.quad;
        status_byte[`FWG_SR_LOCK] = s_q.lock;
        // function byte view
        func_byte = 8'h00;
        func_byte[`FWG_FR_SIDE] = s_q.side;
        // with quad on the pin is a data line, so no hardware lock
        wp_high = s_q.quad | WP_N;
        // classify the framed opcode
        gated = is_gated(CMD.opcode);
        array_op = is_array_op(CMD.opcode);
        whole_erase = (CMD.opcode == `FWG_OP_CE_A) || (CMD.opcode == `FWG_OP_CE_B);
        // protection of the target block
        hit = blk_protected(s_q.level, s_q.side, CMD.block);
        // lock bit plus pin low freezes the status bits
        sr_locked = s_q.lock & ~wp_high;
    end

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    // instruction gate, operation tracking and register port
    always_comb begin
        // hold everything by default
        s_d = s_q;
        // pulses last one cycle
        s_d.grant = 1'b0;
        s_d.reject = 1'b0;
        s_d.rdata = 8'h00;

        // running operation ends when the array engine reports done
        if (s_q.busy && OP_DONE) begin
            s_d.busy = 1'b0;
            s_d.latch = 1'b0;
        end

        // checks are made once the instruction has been framed
        if (CMD_VALID) begin
            if (s_q.busy) begin
                // nothing is taken while an operation runs
                s_d.reject = 1'b1;
            end else if (CMD.opcode == `FWG_OP_LATCH_SET) begin
                // latch set: only the flag moves
                s_d.latch = 1'b1;
            end else if (CMD.opcode == `FWG_OP_LATCH_CLR) begin
                // latch clear: only the flag moves
                s_d.latch = 1'b0;
            end else if (CMD.opcode == `FWG_OP_VBANK_WR) begin
                // volatile write goes straight through
                s_d.grant = 1'b1;
                s_d.grant_op = CMD.opcode;
                s_d.grant_long = ADDR4_MODE;
            end else if (gated) begin
                if (!s_q.latch) begin
                    // latch not set: refused, only the refusal count moves
                    s_d.reject = 1'b1;
                end else if (whole_erase && (s_q.level != 4'h0)) begin
                    // whole array erase needs every level bit clear
                    s_d.reject = 1'b1;
                end else if (array_op && hit) begin
                    // target block sits in the protected region
                    s_d.reject = 1'b1;
                end else if ((CMD.opcode == `FWG_OP_SR_WR) && sr_locked) begin
                    // hardware locked status register
                    s_d.reject = 1'b1;
                end else begin
                    // accepted: start the operation and hold busy
                    s_d.grant = 1'b1;
                    s_d.grant_op = CMD.opcode;
                    s_d.grant_long = is_long_op(CMD.opcode) | ADDR4_MODE;
                    s_d.busy = 1'b1;
                    if (CMD.opcode == `FWG_OP_SR_WR) begin
                        // latch bit of the data byte is not used
                        s_d.lock = CMD.data[`FWG_SR_LOCK];
                        s_d.quad = CMD.data[`FWG_SR_QUAD];
                        s_d.level = CMD.data[`FWG_SR_LVL_LO +: 4];
                    end
                    if (CMD.opcode == `FWG_OP_FR_WR) begin
                        // side select is one-time: it can only be set
                        s_d.side = s_q.side | CMD.data[`FWG_FR_SIDE];
                    end
                end
            end else begin
                // ungated instruction: forwarded without checks
                s_d.grant = 1'b1;
                s_d.grant_op = CMD.opcode;
                s_d.grant_long = is_long_op(CMD.opcode) | ADDR4_MODE;
            end
        end

        // register port writes
        if (REG_WR) begin
            unique case (REG_ADDR)
                // side select may be set, never cleared
                `FWG_REG_FUNC: s_d.side = s_d.side | REG_WDATA[`FWG_FR_SIDE];
                // any write clears the refusal count
                `FWG_REG_REJECTS: s_d.rejects = 8'h00;
                // status is read-only here, offset three unmapped
                default: s_d.rejects = s_d.rejects;
            endcase
        end

        // a refusal in the clearing cycle still counts
        if (s_d.reject && (s_d.rejects != REJ_MAX)) begin
            s_d.rejects = s_d.rejects + 8'h01;
        end

        // read data stands the cycle after the strobe
        if (REG_RD) begin
            unique case (REG_ADDR)
                // status byte with live busy and latch
                `FWG_REG_STATUS: s_d.rdata = status_byte;
                // function byte
                `FWG_REG_FUNC: s_d.rdata = func_byte;
                // refusal count
                `FWG_REG_REJECTS: s_d.rdata = s_q.rejects;
                // unmapped reads as zero
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    // synchronous reset to factory defaults
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            // every field back to zero
            s_q <= '0;
        end else begin
            // take the next state
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flops

    // register port
    assign REG_RDATA = s_q.rdata;
    // operation hand-off
    assign GRANT = s_q.grant;
    assign GRANT_OPCODE = s_q.grant_op;
    assign GRANT_LONG_ADDR = s_q.grant_long;
    // refusal pulse
    assign REJECT = s_q.reject;
    // status levels
    assign BUSY = s_q.busy;
    assign WRITE_LATCH = s_q.latch;
    // pin function select
    assign QUAD_IO_EN = s_q.quad;
    assign WP_FUNC_EN = ~s_q.quad;
    assign PAUSE_FUNC_EN = ~s_q.quad;

endmodule // fwg_guard

`default_nettype wire

// [fwg_guard_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// watches the guard's ports only
module fwg_guard_asserts
    import fwg_pkg::*;
#(
    parameter int REJ_LIMIT = 255 // saturation of the refusal count
) (
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire fwg_cmd_t CMD,
    input wire logic CMD_VALID,
    input wire logic OP_DONE,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic GRANT,
    input wire logic [7:0] GRANT_OPCODE,
    input wire logic GRANT_LONG_ADDR,
    input wire logic REJECT,
    input wire logic BUSY,
    input wire logic WRITE_LATCH,
    input wire logic QUAD_IO_EN,
    input wire logic WP_FUNC_EN,
    input wire logic PAUSE_FUNC_EN
);
    default clocking dcb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    ////////////////////////////////////////////////////////////////////////////////
    // latch commands
    a_latch_set: assert property (CMD_VALID && !BUSY && CMD.opcode == 8'h06
        |=> WRITE_LATCH && !GRANT && !REJECT) else $error("latch set not taken");
    a_latch_clear: assert property (CMD_VALID && !BUSY && CMD.opcode == 8'h04
        |=> !WRITE_LATCH && !GRANT && !REJECT) else $error("latch clear not taken");
    a_latch_hold: assert property (!CMD_VALID && !(BUSY && OP_DONE)
        |=> $stable(WRITE_LATCH)) else $error("latch moved on its own");
    a_done_clears: assert property (BUSY && OP_DONE |=> !BUSY && !WRITE_LATCH)
        else $error("finish did not clear busy and latch");
    // refusals and the ungated volatile write
    a_busy_refuses: assert property (BUSY && CMD_VALID |=> REJECT && !GRANT)
        else $error("command taken while busy");
    a_gate_refuses: assert property (CMD_VALID && !BUSY && !WRITE_LATCH
        && CMD.opcode inside {8'h02, 8'hD8, 8'h01, 8'hA6, 8'h64, 8'h62}
        |=> REJECT && !BUSY) else $error("gated opcode passed without latch");
    a_vbank_free: assert property (CMD_VALID && !BUSY && CMD.opcode == 8'hC5
        |=> GRANT && !BUSY) else $error("volatile bank write refused");
    // grant, pin select and read data outputs
    a_grant_source: assert property (GRANT |-> $past(CMD_VALID)
        && GRANT_OPCODE == $past(CMD.opcode) && !REJECT) else $error("grant without cause");
    a_long_addr: assert property (GRANT && GRANT_OPCODE == 8'h12 |-> GRANT_LONG_ADDR)
        else $error("long program without long address");
    a_quad_pins: assert property (QUAD_IO_EN != WP_FUNC_EN && PAUSE_FUNC_EN == WP_FUNC_EN)
        else $error("pin functions disagree with quad bit");
    a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 8'h00)
        else $error("read data outside its cycle");
endmodule // fwg_guard_asserts
bind fwg_guard fwg_guard_asserts #(.REJ_LIMIT(REJ_LIMIT)) i_chk (.MCLK(MCLK),
    .RESET_N(RESET_N), .CMD(CMD), .CMD_VALID(CMD_VALID), .OP_DONE(OP_DONE), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .GRANT(GRANT), .GRANT_OPCODE(GRANT_OPCODE), .REJECT(REJECT),
    .GRANT_LONG_ADDR(GRANT_LONG_ADDR), .BUSY(BUSY), .WRITE_LATCH(WRITE_LATCH),
    .QUAD_IO_EN(QUAD_IO_EN), .WP_FUNC_EN(WP_FUNC_EN), .PAUSE_FUNC_EN(PAUSE_FUNC_EN));
`default_nettype wire

// [fwg_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// host side: frames one instruction at a time and plays the array engine
module fwg_host_model
    import fwg_pkg::*;
(
    input wire logic clk,
    input wire logic busy,
    input wire logic [7:0] delay,
    output fwg_cmd_t cmd,
    output logic cmd_valid,
    output logic op_done
);
    logic [7:0] cnt_q; // cycles the running operation has taken
    // idle at time zero
    initial begin
        cmd = '0;
        cmd_valid = 1'b0;
        op_done = 1'b0;
        cnt_q = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // one framing; the caller sends the latch set ahead of gated ones
    task automatic send(input logic [7:0] op, input logic [8:0] blk, input logic [7:0] dat);
        @(posedge clk);
        cmd <= {op, blk, dat};
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        // released lines show no stale value
        cmd <= ~{op, blk, dat};
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // engine finishes after delay cycles, prompt when delay is zero
    always @(posedge clk) begin
        if (busy && !op_done) begin
            if (cnt_q >= delay) begin
                op_done <= 1'b1;
                cnt_q <= 8'h00;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end else begin
            op_done <= 1'b0;
        end
    end
endmodule // fwg_host_model
`default_nettype wire

// [fwg_pkg.sv]
`include "fwg_defs.svh"
package fwg_pkg;
    // one framed instruction
    typedef struct packed {
        logic [7:0] opcode;
        logic [`FWG_BLK_W-1:0] block;
        logic [7:0] data;
    } fwg_cmd_t;
    // whole module state
    typedef struct packed {
        logic latch;
        logic lock;
        logic quad;
        logic [3:0] level;
        logic side;
        logic busy;
        logic grant;
        logic [7:0] grant_op;
        logic grant_long;
        logic reject;
        logic [7:0] rejects;
        logic [7:0] rdata;
    } fwg_state_t;
endpackage

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin failures++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
////////////////////////////////////////////////////////////////////////////////
module tb
    import fwg_pkg::*;
;
    logic MCLK = 0, RESET_N = 0, ADDR4_MODE = 0, WP_N = 1, REG_WR = 0, REG_RD = 0;
    logic [1:0] REG_ADDR = 0;
    logic [7:0] REG_WDATA = 0, delay = 0, REG_RDATA, GRANT_OPCODE;
    fwg_cmd_t CMD;
    logic CMD_VALID, OP_DONE, GRANT, GRANT_LONG_ADDR, REJECT, BUSY, WRITE_LATCH;
    logic QUAD_IO_EN, WP_FUNC_EN, PAUSE_FUNC_EN;
    int failures = 0, total_checks = 0, m_rej = 0; // counts and model refusal count
    logic m_latch = 0, m_busy = 0, m_lock = 0, m_quad = 0, m_side = 0; // model state
    logic [3:0] m_level = 0;
    logic [31:0] seed = 32'h5B70;
    // block-addressed program and erase opcodes, then the other gated ones
    logic [7:0] arr_ops [13] = '{8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3E, 8'hD7, 8'h20,
        8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC};
    logic [7:0] reg_ops [17] = '{8'hC7, 8'h60, 8'h01, 8'h42, 8'h65, 8'h85, 8'h64, 8'h62,
        8'h15, 8'h18, 8'hFD, 8'hE3, 8'hE4, 8'h2F, 8'hA6, 8'h91, 8'hE8};
    fwg_guard #(.REJ_LIMIT(3)) i_dut (.MCLK(MCLK), .RESET_N(RESET_N), .CMD(CMD),
        .CMD_VALID(CMD_VALID), .ADDR4_MODE(ADDR4_MODE), .OP_DONE(OP_DONE), .WP_N(WP_N),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .GRANT(GRANT), .GRANT_OPCODE(GRANT_OPCODE),
        .GRANT_LONG_ADDR(GRANT_LONG_ADDR), .REJECT(REJECT), .BUSY(BUSY),
        .WRITE_LATCH(WRITE_LATCH), .QUAD_IO_EN(QUAD_IO_EN), .WP_FUNC_EN(WP_FUNC_EN),
        .PAUSE_FUNC_EN(PAUSE_FUNC_EN));
    fwg_host_model i_host (.clk(MCLK), .busy(BUSY), .delay(delay), .cmd(CMD),
        .cmd_valid(CMD_VALID), .op_done(OP_DONE));
    always #4 MCLK = ~MCLK;
    ////////////////////////////////////////////////////////////////////////////////
    // xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // protected region of the model
    function automatic bit prot(int b);
        int span;
        if (m_level == 0) return 0;
        if (m_level >= 10) return 1;
        span = 1 << (m_level - 1);
        return m_side ? (b < span) : (b >= 512 - span);
    endfunction
    // register port: read data checked in the cycle after the strobe
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge MCLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge MCLK);
        REG_RD <= 1'b0;
        #1;
        `CHK("reg read", e, REG_RDATA)
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge MCLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge MCLK);
        REG_WR <= 1'b0;
    endtask
    // wait for the engine, then the latch must be gone
    task automatic wait_idle();
        int n;
        n = 0;
        while (BUSY === 1'b1 && n < 300) begin
            @(posedge MCLK);
            #1;
            n++;
        end
        if (n == 300) begin
            failures++;
            give_verdict();
        end
        m_busy = 0;
        m_latch = 0;
        `CHK("latch after op", 1'b0, WRITE_LATCH)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // one instruction: predict, send, compare; ok 0 refused, 1 granted, 2 latch command
    task automatic cmd(input logic [7:0] op, input logic [8:0] blk, input logic [7:0] d,
        input bit hold = 0);
        int ok;
        logic a4, g, lng;
        a4 = rnd() % 2 != 0;
        g = op inside {arr_ops, reg_ops};
        lng = a4 || op inside {8'h12, 8'h34, 8'h3E, 8'h21, 8'h5C, 8'hDC, 8'hE3};
        if (m_busy) ok = 0;
        else if (op == 8'h06 || op == 8'h04) ok = 2;
        else if (!g) ok = 1;
        else if (!m_latch) ok = 0;
        else if ((op == 8'hC7 || op == 8'h60) && m_level != 0) ok = 0;
        else if (op inside {arr_ops} && prot(blk)) ok = 0;
        else if (op == 8'h01 && m_lock && !WP_N && !m_quad) ok = 0;
        else ok = 1;
        @(posedge MCLK);
        ADDR4_MODE <= a4;
        i_host.send(op, blk, d);
        #1;
        if (ok == 2) m_latch = op == 8'h06;
        if (ok == 0 && m_rej < 3) m_rej++;
        if (ok == 1 && g) m_busy = 1;
        if (ok == 1 && op == 8'h01) {m_lock, m_quad, m_level} = d[7:2];
        if (ok == 1 && op == 8'h42) m_side |= d[1];
        `CHK("grant", logic'(ok == 1), GRANT)
        `CHK("reject", logic'(ok == 0), REJECT)
        `CHK("latch", m_latch, WRITE_LATCH)
        `CHK("busy", m_busy, BUSY)
        `CHK("pins", {m_quad, !m_quad, !m_quad}, {QUAD_IO_EN, WP_FUNC_EN, PAUSE_FUNC_EN})
        if (ok == 1) `CHK("grant op", {op, lng}, {GRANT_OPCODE, GRANT_LONG_ADDR})
        if (m_busy && !hold) wait_idle();
        if (!m_busy) rd(2'h0, {m_lock, m_quad, m_level, m_latch, m_busy});
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        int sp;
        int pts [6];
        repeat (6) @(posedge MCLK);
        RESET_N <= 1'b1;
        // every gated opcode without the latch, then with it, engine prompt to slow for the block-addressed ones
        foreach (arr_ops[i]) cmd(arr_ops[i], 9'(rnd()), 8'h00);
        foreach (reg_ops[i]) cmd(reg_ops[i], 9'(rnd()), 8'h00);
        foreach (arr_ops[i]) begin
            delay = 8'(i * 3);
            cmd(8'h06, 9'h000, 8'h00);
            cmd(arr_ops[i], 9'(rnd()), 8'h00);
        end
        foreach (reg_ops[i]) begin
            cmd(8'h06, 9'h000, 8'h00);
            cmd(reg_ops[i], 9'(rnd()), 8'h00);
        end
        // clear after set, then ungated write, then commands while busy
        cmd(8'h06, 9'h000, 8'h00);
        cmd(8'h04, 9'h000, 8'h00);
        cmd(8'hD8, 9'h000, 8'h00);
        cmd(8'hC5, 9'h000, 8'h00);
        delay = 8'd30;
        cmd(8'h06, 9'h000, 8'h00);
        cmd(8'hD8, 9'h005, 8'h00, 1);
        cmd(8'h06, 9'h000, 8'h00, 1);
        cmd(8'h20, 9'h005, 8'h00, 1);
        wait_idle();
        delay = 8'd0;
        // every level on both sides, probing the region edges and whole erase
        for (int s = 0; s < 2; s++) begin
            for (int l = 0; l < 16; l++) begin
                sp = l == 0 ? 1 : (l > 9 ? 512 : 1 << (l - 1));
                cmd(8'h06, 9'h000, 8'h00);
                cmd(8'h01, 9'h000, {2'b00, 4'(l), 2'b11});
                pts = '{0, sp - 1, sp, 511 - sp, 512 - sp, 511};
                foreach (pts[k]) begin
                    cmd(8'h06, 9'h000, 8'h00);
                    cmd(arr_ops[rnd() % 13], 9'(pts[k]), 8'h00);
                end
                cmd(8'h06, 9'h000, 8'h00);
                cmd(s ? 8'hC7 : 8'h60, 9'h000, 8'h00);
            end
            cmd(8'h06, 9'h000, 8'h00);
            cmd(8'h42, 9'h000, 8'h02);
        end
        // hardware lock with the pin low and high; WP_N is driven, so quad may be set
        @(posedge MCLK);
        WP_N <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            if (k == 2) begin
                @(posedge MCLK);
                WP_N <= 1'b1;
            end
            if (k == 3) begin
                @(posedge MCLK);
                WP_N <= 1'b0;
            end
            cmd(8'h06, 9'h000, 8'h00);
            cmd(8'h01, 9'h000, k == 0 ? 8'h80 : (k == 2 ? 8'hC0 : 8'h00));
        end
        // registers: counter saturation and clear, read-only status, unmapped
        rd(2'h2, 8'(m_rej));
        wr(2'h2, 8'h00);
        m_rej = 0;
        rd(2'h2, 8'h00);
        cmd(8'hD8, 9'h000, 8'h00);
        rd(2'h2, 8'(m_rej));
        wr(2'h0, 8'hFF);
        rd(2'h0, {m_lock, m_quad, m_level, m_latch, m_busy});
        wr(2'h1, 8'h00);
        rd(2'h1, {6'h00, m_side, 1'b0});
        wr(2'h3, 8'hFF);
        rd(2'h3, 8'h00);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
